/* bench/cmcr_host.sv */
// Purpose: host controller model on the 3-wire and I2C control ports
// Assumes: pins change 1 ns after a clock edge
// Notes:   SDA is open drain with a pull-up
`timescale 1ns/10ps
module cmcr_host (
	// clock and acknowledge from the device
	input wire logic i_clk,
	input wire logic i_sda_oe,
	input wire logic i_sda_out,
	// control pins
	output logic o_ms_n,
	output logic o_mc,
	output logic o_md,
	output logic o_scl,
	output logic o_sda
);
	logic sda_drv;
	// wire level of both drivers and the pull-up
	assign o_sda = sda_drv & (~i_sda_oe | i_sda_out);
	initial begin
		o_ms_n = 1'b1;
		o_mc = 1'b0;
		o_md = 1'b0;
		o_scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : w
	// fewer than 16 bits gives a short frame
	task automatic spi_word(input logic [15:0] wd, input int n);
		o_ms_n = 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			o_md = wd[i];
			w(5);
			o_mc = 1'b1;
			w(5);
			o_mc = 1'b0;
		end
		w(5);
		o_ms_n = 1'b1;
		o_md = ~o_md;
		w(12);
	endtask : spi_word
	task automatic i2c_start();
		sda_drv = 1'b1;
		o_scl = 1'b1;
		w(20);
		sda_drv = 1'b0;
		w(20);
		o_scl = 1'b0;
		w(10);
	endtask : i2c_start
	task automatic i2c_bit(input logic b, output logic s);
		sda_drv = b;
		w(10);
		o_scl = 1'b1;
		w(10);
		s = o_sda;
		w(10);
		o_scl = 1'b0;
		w(10);
	endtask : i2c_bit
	task automatic i2c_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			i2c_bit(d[i], s);
		i2c_bit(1'b1, s);
		ack = ~s;
	endtask : i2c_byte
	task automatic i2c_stop();
		sda_drv = 1'b0;
		w(10);
		o_scl = 1'b1;
		w(20);
		sda_drv = 1'b1;
		w(40);
	endtask : i2c_stop
endmodule : cmcr_host

/* bench/cmcr_mode_regs_asserts.sv */
// Purpose: port checker for the mode-control register bank
// Assumes: single clock domain, synchronous active-high reset
// Notes:   bound to every cmcr_mode_regs instance
`timescale 1ns/10ps
module cmcr_mode_regs_asserts (
	// clock and reset
	input wire logic I_MCLK,
	input wire logic I_RESET,
	// watched outputs
	input wire logic O_SDA,
	input wire logic O_SDA_OE,
	input wire cmcr_pkg::cmcr_ctrl_t O_CTRL,
	input wire logic O_RESYNC,
	input wire logic O_REGBANK_CLR
);
	import cmcr_pkg::*;
	localparam cmcr_ctrl_t DEF = 62'h37FF_F800_06BE_B800;
	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (I_RESET);
	sequence s_ack_hold;
		O_SDA_OE [*8];
	endsequence
	sequence s_ack_end;
		##[1:120] !O_SDA_OE;
	endsequence
	chk_reset_defaults: assert property (
		$fell(I_RESET) |-> O_CTRL == DEF)
		else $error("defaults missing after reset");
	chk_resync_pulse: assert property (
		O_RESYNC |=> !O_RESYNC)
		else $error("resync pulse longer than one cycle");
	chk_clear_pulse: assert property (
		O_REGBANK_CLR |=> !O_REGBANK_CLR)
		else $error("bank clear pulse longer than one cycle");
	chk_clear_defaults: assert property (
		O_REGBANK_CLR |-> ##[0:1] O_CTRL == DEF)
		else $error("bank clear left non-default fields");
	chk_resync_keeps: assert property (
		O_RESYNC |-> !O_REGBANK_CLR && $stable(O_CTRL[58:0]))
		else $error("resync disturbed stored fields");
	chk_ack_low: assert property (
		O_SDA_OE |-> O_SDA == 1'b0)
		else $error("acknowledge does not pull low");
	chk_ack_hold: assert property (
		$rose(O_SDA_OE) |-> s_ack_hold)
		else $error("acknowledge dropped too early");
	chk_ack_release: assert property (
		$rose(O_SDA_OE) |-> s_ack_end)
		else $error("acknowledge never released");
endmodule : cmcr_mode_regs_asserts

bind cmcr_mode_regs cmcr_mode_regs_asserts cmcr_mode_regs_asserts_inst (
	.I_MCLK(I_MCLK), .I_RESET(I_RESET), .O_SDA(O_SDA),
	.O_SDA_OE(O_SDA_OE), .O_CTRL(O_CTRL), .O_RESYNC(O_RESYNC),
	.O_REGBANK_CLR(O_REGBANK_CLR));

/* bench/tb_cmcr_mode_regs.sv */
// Purpose: self-checking bench for the mode-control register bank
// Assumes: host model drives both control ports
// Notes:   expected fields kept by a local copy of the map
`timescale 1ns/10ps
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin \
	fail_count++; $display("MISMATCH %0t %s", $time, m); end end
module tb_cmcr_mode_regs;
	import cmcr_pkg::*;
	localparam cmcr_ctrl_t DEF = 62'h37FF_F800_06BE_B800;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic adr = 1'b1;
	logic ms_n, mc, md, scl, sda, dut_sda, sda_oe, resync, clr;
	cmcr_ctrl_t ctrl, exp;
	int fail_count, cmp_count, cyc, n_rs, n_clr;
	logic [15:0] rows [10] = '{16'h40C1, 16'h4100, 16'h4237,
		16'h43E3, 16'h4447, 16'h45F3, 16'h46FF, 16'h4700,
		16'h48E1, 16'h491F};
	cmcr_mode_regs cmcr_mode_regs_inst (.I_MCLK(mclk), .I_RESET(reset),
		.I_MS_N(ms_n), .I_MC(mc), .I_MD(md), .I_SCL(scl), .I_SDA(sda),
		.I_ADR(adr), .O_SDA(dut_sda), .O_SDA_OE(sda_oe), .O_CTRL(ctrl),
		.O_RESYNC(resync), .O_REGBANK_CLR(clr));
	cmcr_host cmcr_host_inst (.i_clk(mclk), .i_sda_oe(sda_oe),
		.i_sda_out(dut_sda), .o_ms_n(ms_n), .o_mc(mc), .o_md(md),
		.o_scl(scl), .o_sda(sda));
	always #5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		n_rs += (resync === 1'b1);
		n_clr += (clr === 1'b1);
		if (cyc == 20000) begin
			fail_count++;
			end_of_test();
		end
	end
	function automatic cmcr_ctrl_t apply(cmcr_ctrl_t c, logic [15:0] w);
		logic [7:0] d;
		d = w[7:0];
		case (w[15:8])
			8'h40: if (d[7]) {c.adc_power_save, c.dac_power_save,
				c.dac_single_ended} = {d[5:4], d[0]};
				else c = DEF;
			8'h41: c.dac_left_atten_code = d;
			8'h42: c.dac_right_atten_code = d;
			8'h43: {c.dac_clock_source_sel, c.dac_master_slave_mode,
				c.dac_format_sel} = {d[7:4], d[1:0]};
			8'h44: {c.dac_modulator_rate_sel, c.dac_phase_invert,
				c.dac_right_soft_mute, c.dac_left_soft_mute} = {d[6], d[2:0]};
			8'h45: {c.dac_rolloff_sel, c.deemph_rate_sel, c.deemph_enable,
				c.zero_flag_polarity, c.zero_flag_form} = {d[7:4], d[1:0]};
			8'h46: c.adc_left_atten_code = d;
			8'h47: c.adc_right_atten_code = d;
			8'h48: {c.adc_clock_source_sel, c.adc_master_slave_mode,
				c.adc_format_sel} = {d[7:4], d[1:0]};
			8'h49: {c.adc_zero_cross_disable, c.adc_highpass_skip,
				c.adc_phase_invert, c.adc_right_soft_mute,
				c.adc_left_soft_mute} = d[4:0];
			default: ;
		endcase
		return c;
	endfunction : apply
	task automatic spi(input logic [15:0] wd, input int n);
		cmcr_host_inst.spi_word(wd, n);
		if (n == 16)
			exp = apply(exp, wd);
		`CHK(ctrl, exp, "fields after 3-wire frame")
	endtask : spi
	task automatic xfer(input logic [31:0] b, input int n,
		input logic [3:0] ea);
		logic ack;
		cmcr_host_inst.i2c_start();
		for (int k = 0; k < n; k++) begin
			cmcr_host_inst.i2c_byte(b[31 - 8 * k -: 8], ack);
			`CHK(ack, ea[3 - k], "i2c acknowledge")
		end
		cmcr_host_inst.i2c_stop();
	endtask : xfer
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	initial begin
		exp = DEF;
		repeat (3) @(posedge mclk);
		#1 reset = 1'b0;
		`CHK(ctrl, DEF, "reset fields")
		repeat (2) @(posedge mclk);
		#1;
		foreach (rows[i])
			spi(rows[i], 16);
		spi(16'h41AA, 15);
		spi(16'h4A55, 16);
		spi(16'h40B0, 16);
		`CHK(n_rs, 1, "resync count")
		spi(16'h4000, 16);
		`CHK(n_clr, 1, "bank clear count")
		xfer(32'h8E49_1FC0, 4, 4'hF);
		exp = apply(apply(exp, 16'h491F), 16'h40C0);
		`CHK(ctrl, exp, "i2c index wrap")
		xfer(32'h8C00_0000, 1, 4'h0);
		xfer(32'h8E4A_0000, 2, 4'h8);
		adr = 1'b0;
		xfer(32'h8C41_1200, 3, 4'hE);
		exp = apply(exp, 16'h4112);
		`CHK(ctrl, exp, "i2c with address select low")
		`CHK({n_rs, n_clr}, {32'd1, 32'd1}, "command counts")
		reset = 1'b1;
		repeat (3) @(posedge mclk);
		#1 reset = 1'b0;
		`CHK(ctrl, DEF, "mid-run reset fields")
		end_of_test();
	end
endmodule : tb_cmcr_mode_regs

/* inc/cmcr_map.svh */
// Purpose: register map, field positions and reset values of the codec
//          mode-control bank
// Assumes: 8-bit registers at 40h..49h, 16-bit access word addr/data
// Notes:   included by bare name; definitions only
`ifndef CMCR_MAP_SVH
`define CMCR_MAP_SVH

`define CMCR_OFS_GLOBAL 8'h40
`define CMCR_OFS_DAC_ATT_L 8'h41
`define CMCR_OFS_DAC_ATT_R 8'h42
`define CMCR_OFS_DAC_IF 8'h43
`define CMCR_OFS_DAC_OUT 8'h44
`define CMCR_OFS_DAC_FILT 8'h45
`define CMCR_OFS_ADC_ATT_L 8'h46
`define CMCR_OFS_ADC_ATT_R 8'h47
`define CMCR_OFS_ADC_IF 8'h48
`define CMCR_OFS_ADC_PROC 8'h49

`define CMCR_RST_GLOBAL 8'hF0
`define CMCR_RST_DAC_ATT 8'hFF
`define CMCR_RST_ADC_ATT 8'hD7
`define CMCR_RST_DAC_IF 8'h00
`define CMCR_RST_DAC_OUT 8'h00
`define CMCR_RST_DAC_FILT 8'h00
`define CMCR_RST_ADC_IF 8'h00
`define CMCR_RST_ADC_PROC 8'h00

`define CMCR_B_REGRST 7
`define CMCR_B_RESYNC 6
`define CMCR_B_ADC_PSV 5
`define CMCR_B_DAC_PSV 4
`define CMCR_B_SE 0
`define CMCR_B_CSEL 7
`define CMCR_B_MS_HI 6
`define CMCR_B_MS_LO 4
`define CMCR_B_FMT_HI 1
`define CMCR_B_FMT_LO 0
`define CMCR_B_RATE 6
`define CMCR_B_PHINV 2
`define CMCR_B_MUTE_R 1
`define CMCR_B_MUTE_L 0
`define CMCR_B_ROLLOFF 7
`define CMCR_B_DMF_HI 6
`define CMCR_B_DMF_LO 5
`define CMCR_B_DEEMPH 4
`define CMCR_B_ZPOL 1
`define CMCR_B_ZFORM 0
`define CMCR_B_ZCD 4
`define CMCR_B_HPF 3

`define CMCR_I2C_ADDR_HI 6'h23
`define CMCR_SPI_BITS 5'h10
`define CMCR_I2C_BITS 4'h8
`define CMCR_SYNC_RST 6'h26

`endif

/* inc/cmcr_pkg.sv */
// Purpose: types shared by the mode-control bank modules
// Assumes: field layout per cmcr_map.svh
// Notes:   none
package cmcr_pkg;

	typedef struct packed {
		logic valid;
		logic [7:0] addr;
		logic [7:0] data;
	} cmcr_wr_t;

	typedef struct packed {
		logic adc_power_save;
		logic dac_power_save;
		logic dac_single_ended;
		logic [7:0] dac_left_atten_code;
		logic [7:0] dac_right_atten_code;
		logic dac_clock_source_sel;
		logic [2:0] dac_master_slave_mode;
		logic [1:0] dac_format_sel;
		logic dac_modulator_rate_sel;
		logic dac_phase_invert;
		logic dac_right_soft_mute;
		logic dac_left_soft_mute;
		logic dac_rolloff_sel;
		logic [1:0] deemph_rate_sel;
		logic deemph_enable;
		logic zero_flag_polarity;
		logic zero_flag_form;
		logic [7:0] adc_left_atten_code;
		logic [7:0] adc_right_atten_code;
		logic adc_clock_source_sel;
		logic [2:0] adc_master_slave_mode;
		logic [1:0] adc_format_sel;
		logic adc_zero_cross_disable;
		logic adc_highpass_skip;
		logic adc_phase_invert;
		logic adc_right_soft_mute;
		logic adc_left_soft_mute;
	} cmcr_ctrl_t;

	typedef enum logic [3:0] {
		I2C_IDLE = 4'h1,
		I2C_RECV = 4'h2,
		I2C_ACK = 4'h4,
		I2C_SKIP = 4'h8
	} cmcr_i2c_state_t;

endpackage : cmcr_pkg

/* rtl/cmcr_mode_regs.sv */
// Purpose: mode-control register bank with 3-wire and I2C write ports
// Assumes: single 100 MHz clock, synchronous active-high reset;
//          serial clocks far slower than I_MCLK
// Notes:   write-only bank; bank reset and resync are one-shot commands
`timescale 1ns/10ps
module cmcr_mode_regs (
	// clock and reset
	input wire logic I_MCLK,
	input wire logic I_RESET,
	// 3-wire control port
	input wire logic I_MS_N,
	input wire logic I_MC,
	input wire logic I_MD,
	// I2C control port
	input wire logic I_SCL,
	input wire logic I_SDA,
	input wire logic I_ADR,
	output logic O_SDA,
	output logic O_SDA_OE,
	// decoded mode fields and commands
	output cmcr_pkg::cmcr_ctrl_t O_CTRL,
	output logic O_RESYNC,
	output logic O_REGBANK_CLR
);
	import cmcr_pkg::*;
	`include "cmcr_map.svh"

	logic [5:0] pins_s;
	logic ms_n_s;
	logic mc_s;
	logic md_s;
	logic scl_s;
	logic sda_s;
	logic adr_s;

	cmcr_wr_t spi_wr;
	cmcr_wr_t i2c_wr;
	cmcr_wr_t wr;

	logic scl_d;
	logic sda_d;
	logic scl_rise;
	logic scl_fall;
	logic i2c_start;
	logic i2c_stop;

	cmcr_i2c_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic [1:0] phase;
	logic [7:0] index;
	logic next_ack;

	localparam logic [1:0] PH_SLAVE = 2'h0;
	localparam logic [1:0] PH_REG = 2'h1;
	localparam logic [1:0] PH_DATA = 2'h2;

	cmcr_ctrl_t ctrl;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// one window check serves both ports and the I2C acknowledge
	function automatic logic addr_ok(input logic [7:0] a);
		return (a >= `CMCR_OFS_GLOBAL) && (a <= `CMCR_OFS_ADC_PROC);
	endfunction : addr_ok

	// reserved bits are dropped, not stored
	function automatic cmcr_ctrl_t put_byte(
		input cmcr_ctrl_t c,
		input logic [7:0] a,
		input logic [7:0] d
	);
		cmcr_ctrl_t r;
		r = c;
		case (a)
			`CMCR_OFS_GLOBAL: begin
				r.adc_power_save = d[`CMCR_B_ADC_PSV];
				r.dac_power_save = d[`CMCR_B_DAC_PSV];
				r.dac_single_ended = d[`CMCR_B_SE];
			end
			`CMCR_OFS_DAC_ATT_L: begin
				r.dac_left_atten_code = d;
			end
			`CMCR_OFS_DAC_ATT_R: begin
				r.dac_right_atten_code = d;
			end
			`CMCR_OFS_DAC_IF: begin
				r.dac_clock_source_sel = d[`CMCR_B_CSEL];
				r.dac_master_slave_mode =
					d[`CMCR_B_MS_HI:`CMCR_B_MS_LO];
				r.dac_format_sel =
					d[`CMCR_B_FMT_HI:`CMCR_B_FMT_LO];
			end
			`CMCR_OFS_DAC_OUT: begin
				r.dac_modulator_rate_sel = d[`CMCR_B_RATE];
				r.dac_phase_invert = d[`CMCR_B_PHINV];
				r.dac_right_soft_mute = d[`CMCR_B_MUTE_R];
				r.dac_left_soft_mute = d[`CMCR_B_MUTE_L];
			end
			`CMCR_OFS_DAC_FILT: begin
				r.dac_rolloff_sel = d[`CMCR_B_ROLLOFF];
				r.deemph_rate_sel =
					d[`CMCR_B_DMF_HI:`CMCR_B_DMF_LO];
				r.deemph_enable = d[`CMCR_B_DEEMPH];
				r.zero_flag_polarity = d[`CMCR_B_ZPOL];
				r.zero_flag_form = d[`CMCR_B_ZFORM];
			end
			`CMCR_OFS_ADC_ATT_L: begin
				r.adc_left_atten_code = d;
			end
			`CMCR_OFS_ADC_ATT_R: begin
				r.adc_right_atten_code = d;
			end
			`CMCR_OFS_ADC_IF: begin
				r.adc_clock_source_sel = d[`CMCR_B_CSEL];
				r.adc_master_slave_mode =
					d[`CMCR_B_MS_HI:`CMCR_B_MS_LO];
				r.adc_format_sel =
					d[`CMCR_B_FMT_HI:`CMCR_B_FMT_LO];
			end
			`CMCR_OFS_ADC_PROC: begin
				r.adc_zero_cross_disable = d[`CMCR_B_ZCD];
				r.adc_highpass_skip = d[`CMCR_B_HPF];
				r.adc_phase_invert = d[`CMCR_B_PHINV];
				r.adc_right_soft_mute = d[`CMCR_B_MUTE_R];
				r.adc_left_soft_mute = d[`CMCR_B_MUTE_L];
			end
			default: begin
				r = c;
			end
		endcase
		return r;
	endfunction : put_byte

	// power-on image of the whole bank
	// built through put_byte so reset image and decode cannot drift apart
	function automatic cmcr_ctrl_t bank_default();
		cmcr_ctrl_t r;
		r = '0;
		r = put_byte(r, `CMCR_OFS_GLOBAL, `CMCR_RST_GLOBAL);
		r = put_byte(r, `CMCR_OFS_DAC_ATT_L, `CMCR_RST_DAC_ATT);
		r = put_byte(r, `CMCR_OFS_DAC_ATT_R, `CMCR_RST_DAC_ATT);
		r = put_byte(r, `CMCR_OFS_DAC_IF, `CMCR_RST_DAC_IF);
		r = put_byte(r, `CMCR_OFS_DAC_OUT, `CMCR_RST_DAC_OUT);
		r = put_byte(r, `CMCR_OFS_DAC_FILT, `CMCR_RST_DAC_FILT);
		r = put_byte(r, `CMCR_OFS_ADC_ATT_L, `CMCR_RST_ADC_ATT);
		r = put_byte(r, `CMCR_OFS_ADC_ATT_R, `CMCR_RST_ADC_ATT);
		r = put_byte(r, `CMCR_OFS_ADC_IF, `CMCR_RST_ADC_IF);
		r = put_byte(r, `CMCR_OFS_ADC_PROC, `CMCR_RST_ADC_PROC);
		return r;
	endfunction : bank_default

	// ---------------------------------------------------------------
	// pin synchronisers and the 3-wire receiver
	// ---------------------------------------------------------------
	// all pins share one synchroniser depth, so their order is kept
	cmcr_sync #(
		.W(6),
		.RST_VAL(`CMCR_SYNC_RST)
	) u_sync (
		.i_clk(I_MCLK),
		.i_reset(I_RESET),
		.i_async({I_MS_N, I_MC, I_MD, I_SCL, I_SDA, I_ADR}),
		.o_sync(pins_s)
	);

	assign ms_n_s = pins_s[5];
	assign mc_s = pins_s[4];
	assign md_s = pins_s[3];
	assign scl_s = pins_s[2];
	assign sda_s = pins_s[1];
	assign adr_s = pins_s[0];

	// 3-wire words arrive whole; short frames never reach the bank
	cmcr_spi_rx u_spi (
		.i_clk(I_MCLK),
		.i_reset(I_RESET),
		.i_sel_n(ms_n_s),
		.i_sclk(mc_s),
		.i_sdat(md_s),
		.o_wr(spi_wr)
	);

	// ---------------------------------------------------------------
	// I2C slave receiver
	// ---------------------------------------------------------------
	// idle-high history keeps a false START or STOP out after reset
	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	assign scl_rise = scl_s && !scl_d;
	assign scl_fall = !scl_s && scl_d;
	// SCL must be high on both samples, so data moving near a clock
	// edge is never taken for START or STOP
	assign i2c_start = scl_s && scl_d && sda_d && !sda_s;
	assign i2c_stop = scl_s && scl_d && !sda_d && sda_s;

	// acknowledge decision for the byte just shifted in
	// a refusal makes the rest of the transfer be ignored
	always_comb begin
		next_ack = 1'b0;
		case (phase)
			PH_SLAVE: begin
				next_ack = (shreg[7:1] == {`CMCR_I2C_ADDR_HI, adr_s}) &&
					!shreg[0];
			end
			PH_REG: begin
				next_ack = addr_ok(shreg);
			end
			PH_DATA: begin
				next_ack = addr_ok(index);
			end
			default: begin
				next_ack = 1'b0;
			end
		endcase
	end

	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			state <= I2C_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			phase <= PH_SLAVE;
			index <= `CMCR_OFS_GLOBAL;
			O_SDA_OE <= 1'b0;
			i2c_wr <= '0;
		end else begin
			i2c_wr.valid <= 1'b0;
			if (i2c_stop) begin
				state <= I2C_IDLE;
				O_SDA_OE <= 1'b0;
			end else if (i2c_start) begin
				state <= I2C_RECV;
				bit_cnt <= 4'h0;
				phase <= PH_SLAVE;
				O_SDA_OE <= 1'b0;
			end else begin
				case (state)
					I2C_IDLE: begin
						O_SDA_OE <= 1'b0;
					end
					I2C_RECV: begin
						if (scl_rise && bit_cnt != `CMCR_I2C_BITS) begin
							shreg <= {shreg[6:0], sda_s};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall &&
							bit_cnt == `CMCR_I2C_BITS) begin
							bit_cnt <= 4'h0;
							O_SDA_OE <= next_ack;
							state <= next_ack ? I2C_ACK : I2C_SKIP;
							if (phase == PH_SLAVE) begin
								phase <= PH_REG;
							end else if (phase == PH_REG) begin
								// kept even when refused
								phase <= PH_DATA;
								index <= shreg;
							end else if (next_ack) begin
								// index moves only on an accepted data byte
								i2c_wr.valid <= 1'b1;
								i2c_wr.addr <= index;
								i2c_wr.data <= shreg;
								if (index == `CMCR_OFS_ADC_PROC) begin
									index <= `CMCR_OFS_GLOBAL;
								end else begin
									index <= index + 8'h01;
								end
							end
						end
					end
					I2C_ACK: begin
						// free the line on the ninth fall
						if (scl_fall) begin
							O_SDA_OE <= 1'b0;
							state <= I2C_RECV;
						end
					end
					I2C_SKIP: begin
						// refused transfer: wait for START or STOP
						O_SDA_OE <= 1'b0;
					end
					default: begin
						// recover from an illegal code
						state <= I2C_IDLE;
						O_SDA_OE <= 1'b0;
					end
				endcase
			end
		end
	end

	// pin is only ever pulled low; the enable does the work
	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			O_SDA <= 1'b0;
		end else begin
			O_SDA <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// register bank
	// ---------------------------------------------------------------
	// 3-wire word takes precedence if both ports finish together
	assign wr = spi_wr.valid ? spi_wr : i2c_wr;

	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			ctrl <= bank_default();
			O_RESYNC <= 1'b0;
			O_REGBANK_CLR <= 1'b0;
		end else begin
			O_RESYNC <= 1'b0;
			O_REGBANK_CLR <= 1'b0;
			if (wr.valid && addr_ok(wr.addr)) begin
				if (wr.addr == `CMCR_OFS_GLOBAL &&
					!wr.data[`CMCR_B_REGRST]) begin
					// command bit is never stored; the bank reloads its defaults
					ctrl <= bank_default();
					O_REGBANK_CLR <= 1'b1;
				end else begin
					// resync still stores the other bits of the byte
					ctrl <= put_byte(ctrl, wr.addr, wr.data);
					if (wr.addr == `CMCR_OFS_GLOBAL &&
						!wr.data[`CMCR_B_RESYNC]) begin
						O_RESYNC <= 1'b1;
					end
				end
			end
		end
	end

	assign O_CTRL = ctrl;

endmodule : cmcr_mode_regs

/* rtl/cmcr_spi_rx.sv */
// Purpose: 3-wire serial receiver, one 16-bit write word per frame
// Assumes: inputs already synchronised; data sampled on clock rise
// Notes:   frame shorter than 16 bits is dropped; longer keeps last 16
`timescale 1ns/10ps
module cmcr_spi_rx (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// synchronised serial lines
	input wire logic i_sel_n,
	input wire logic i_sclk,
	input wire logic i_sdat,
	// completed write word
	output cmcr_pkg::cmcr_wr_t o_wr
);
	import cmcr_pkg::*;
	`include "cmcr_map.svh"

	logic sclk_d;
	logic sel_n_d;
	logic [4:0] cnt;
	logic [15:0] shreg;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			sclk_d <= 1'b0;
			sel_n_d <= 1'b1;
		end else begin
			sclk_d <= i_sclk;
			sel_n_d <= i_sel_n;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			cnt <= 5'h00;
			shreg <= 16'h0000;
		end else if (i_sel_n) begin
			cnt <= 5'h00;
		end else if (i_sclk && !sclk_d) begin
			shreg <= {shreg[14:0], i_sdat};
			if (cnt != `CMCR_SPI_BITS) begin
				cnt <= cnt + 5'h01;
			end
		end
	end

	// word is handed over only when the frame closes
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_wr <= '0;
		end else begin
			o_wr.valid <= i_sel_n && !sel_n_d &&
				(cnt == `CMCR_SPI_BITS);
			o_wr.addr <= shreg[15:8];
			o_wr.data <= shreg[7:0];
		end
	end

endmodule : cmcr_spi_rx

/* rtl/cmcr_sync.sv */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to i_clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module cmcr_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// pins and synchronised copy
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			meta <= RST_VAL;
			o_sync <= RST_VAL;
		end else begin
			meta <= i_async;
			o_sync <= meta;
		end
	end

endmodule : cmcr_sync
